// *** verilog/ssp_map.svh ***
// constants of the sensor serial register port: frame layout and special addresses
// assumes inclusion by the package and the bench only
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// register address width and data width of one frame byte
`define SSP_ADDR_W      7
`define SSP_DATA_W      8
// index of the last bit of a byte
`define SSP_LAST_BIT    3'h7
// direction bit value that marks a read
`define SSP_DIR_READ    1'b1
// address of the queue readout register
`define SSP_QUEUE_ADDR  7'h40
// reset values
`define SSP_ADDR_RST    7'h00
`define SSP_BYTE_RST    8'h00
`define SSP_CNT_RST     3'h0

`endif

// *** verilog/ssp_pkg.sv ***
// types shared by the sensor serial register port
// assumes the map header is on the include path
`include "ssp_map.svh"

package ssp_pkg;

    typedef logic [`SSP_ADDR_W-1:0] ssp_addr_t;
    typedef logic [`SSP_DATA_W-1:0] ssp_byte_t;

    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_CMD,
        SSP_WDATA,
        SSP_RDATA
    } ssp_state_t;

endpackage

// *** verilog/ssp_sync.sv ***
// two flip-flop synchroniser, one stage pair per bit
// assumes asynchronous pin levels at its inputs and one destination clock
`timescale 1ns/1ps

module ssp_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    // reset to the idle high level of chip select, so no false frame start follows reset
                    meta_q[gi]   <= 1'b1;
                    sync_out[gi] <= 1'b1;
                end else begin
                    meta_q[gi]   <= async_in[gi];
                    sync_out[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule

// *** verilog/ssp_spi_port.sv ***
// serial slave port giving a host read and write access to internal registers
// assumes a register file on core_clk that answers a read strobe with data on the next cycle
`timescale 1ns/1ps

module ssp_spi_port
    import ssp_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      srst,
    // serial pins
    input  wire logic      chip_select_n,
    input  wire logic      serial_clock,
    input  wire logic      serial_data_io_i,
    output logic           serial_data_io_o,
    output logic           serial_data_io_oe_n,
    output logic           serial_data_out_o,
    output logic           serial_data_out_oe_n,
    // configuration
    input  wire logic      three_wire_select,
    // register access
    output ssp_addr_t      reg_addr_q,
    output ssp_byte_t      reg_wdata_q,
    output logic           reg_wr_q,
    output logic           reg_rd_q,
    input  wire ssp_byte_t reg_rdata,
    // status
    output logic           clock_mode_q
);

    logic [2:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       din_s;
    logic       sck_prev_q;
    logic       sck_rise;
    logic       sck_fall;
    logic       frame_start;
    logic       frame_end;
    logic       cs_prev_q;

    ssp_state_t state_q;
    logic [2:0] bit_cnt_q;
    ssp_byte_t  rx_q;
    ssp_byte_t  rx_full;
    ssp_byte_t  tx_q;
    logic       load_q;
    logic       tx_bit_q;
    logic       tx_on_q;
    logic       byte_done;

    ssp_sync #(
        .W (3)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in ({chip_select_n, serial_clock, serial_data_io_i}),
        .sync_out (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sck_s  = pins_s[1];
    assign din_s  = pins_s[0];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sck_prev_q <= 1'b1;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    assign frame_start = cs_prev_q & ~cs_n_s;
    assign frame_end   = cs_n_s;
    assign sck_rise    = ~cs_n_s & sck_s & ~sck_prev_q;
    assign sck_fall    = ~cs_n_s & ~sck_s & sck_prev_q;
    assign rx_full     = {rx_q[6:0], din_s};
    assign byte_done   = sck_rise && (bit_cnt_q == `SSP_LAST_BIT);

    // clock polarity caught at the chip select fall; host keeps sck still then
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clock_mode_q <= 1'b0;
        end else if (frame_start) begin
            clock_mode_q <= sck_s;
        end
    end

    // bit counter and receive shifter
    always_ff @(posedge core_clk) begin
        if (srst || frame_end || frame_start) begin
            bit_cnt_q <= `SSP_CNT_RST;
            rx_q      <= `SSP_BYTE_RST;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q      <= rx_full;
        end
    end

    // frame sequencing
    always_ff @(posedge core_clk) begin
        if (srst || frame_end) begin
            state_q <= SSP_IDLE;
        end else begin
            case (state_q)
                SSP_IDLE: begin
                    if (frame_start) begin
                        state_q <= SSP_CMD;
                    end
                end
                SSP_CMD: begin
                    if (byte_done) begin
                        if (rx_full[7] == `SSP_DIR_READ) begin
                            state_q <= SSP_RDATA;
                        end else begin
                            state_q <= SSP_WDATA;
                        end
                    end
                end
                SSP_WDATA: begin
                    if (byte_done) begin
                        state_q <= SSP_CMD;
                    end
                end
                default: begin
                    state_q <= SSP_RDATA;
                end
            endcase
        end
    end

    // register address, write data and strobes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_addr_q  <= `SSP_ADDR_RST;
            reg_wdata_q <= `SSP_BYTE_RST;
            reg_wr_q    <= 1'b0;
            reg_rd_q    <= 1'b0;
        end else begin
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            if (byte_done && state_q == SSP_CMD) begin
                reg_addr_q <= rx_full[6:0];
                reg_rd_q   <= (rx_full[7] == `SSP_DIR_READ);
            end else if (byte_done && state_q == SSP_WDATA) begin
                reg_wdata_q <= rx_full;
                reg_wr_q    <= 1'b1;
            end else if (byte_done && state_q == SSP_RDATA) begin
                reg_rd_q <= 1'b1;
                if (reg_addr_q != `SSP_QUEUE_ADDR) begin
                    reg_addr_q <= reg_addr_q + 7'h01;
                end
            end
        end
    end

    // transmit shifter: loaded after each read strobe, shifted on falling edges
    always_ff @(posedge core_clk) begin
        if (srst || frame_end) begin
            load_q   <= 1'b0;
            tx_q     <= `SSP_BYTE_RST;
            tx_bit_q <= 1'b0;
        end else begin
            load_q <= reg_rd_q;
            if (load_q) begin
                tx_q <= reg_rdata;
            end else if (sck_fall && state_q == SSP_RDATA) begin
                tx_bit_q <= tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // three-wire turnaround: take the io pin only after the host lets go at the first falling edge
    always_ff @(posedge core_clk) begin
        if (srst || frame_end) begin
            tx_on_q <= 1'b0;
        end else if (sck_fall && state_q == SSP_RDATA) begin
            tx_on_q <= 1'b1;
        end
    end

    // pad drive: three-wire answers on the io pin, four-wire on both the output pin and the io pin
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_data_io_o     <= 1'b0;
            serial_data_io_oe_n  <= 1'b0;
            serial_data_out_o    <= 1'b0;
            serial_data_out_oe_n <= 1'b1;
        end else begin
            serial_data_out_o <= tx_bit_q;
            serial_data_io_o  <= tx_bit_q;
            serial_data_out_oe_n <= three_wire_select || state_q != SSP_RDATA;
            if (three_wire_select) begin
                serial_data_io_oe_n <= ~tx_on_q;
            end else begin
                serial_data_io_oe_n <= ~(cs_n_s || state_q == SSP_RDATA);
            end
        end
    end

endmodule

// *** tb/ssp_spi_port_chk.sv ***
// assertions on the serial port pins and register strobes
// assumes a bind into ssp_spi_port and one clock domain
`timescale 1ns/1ps

module ssp_spi_port_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // watched ports
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic three_wire_select,
    input wire logic serial_data_io_oe_n,
    input wire logic serial_data_out_oe_n,
    input wire logic reg_wr_q,
    input wire logic reg_rd_q,
    input wire logic clock_mode_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    mode_one_a: assert property ((chip_select_n && serial_clock)[*8] ##1 !chip_select_n |-> ##8 clock_mode_q)
        else $error("mode 11 missed");
    mode_zero_a: assert property ((chip_select_n && !serial_clock)[*8] ##1 !chip_select_n |-> ##8 !clock_mode_q)
        else $error("mode 00 missed");
    rst_drive_a: assert property ($fell(srst) |-> !serial_data_io_oe_n && serial_data_out_oe_n)
        else $error("reset drive");
    wr_once_a: assert property (reg_wr_q |-> !chip_select_n ##1 !reg_wr_q)
        else $error("write strobe");
    rd_gap_a: assert property (reg_rd_q |-> !chip_select_n ##1 !reg_rd_q [*8])
        else $error("read strobe");
    idle_quiet_a: assert property (chip_select_n [*8] |-> serial_data_out_oe_n && !reg_wr_q && !reg_rd_q)
        else $error("idle activity");
    three_idle_a: assert property ((three_wire_select && chip_select_n) [*8] |-> serial_data_io_oe_n)
        else $error("io driven");
    four_idle_a: assert property ((!three_wire_select && chip_select_n) [*8] |-> !serial_data_io_oe_n)
        else $error("io released");
    cover property (reg_wr_q);
    cover property (reg_rd_q);
    cover property ($rose(clock_mode_q));
endmodule

bind ssp_spi_port ssp_spi_port_chk ssp_spi_port_chk_i (.*);

// *** tb/ssp_host.sv ***
// host side model: frames, bytes, clock modes 00 and 11
// assumes the bench clock; a link half period is 20 core_clk cycles
`timescale 1ns/1ps

module ssp_host (
    // clock
    input  wire logic core_clk,
    // link
    output logic      cs_n,
    output logic      sck,
    output logic      mosi,
    output logic      drv,
    input  wire logic miso
);
    initial {cs_n, sck} = 2'h2;
    task automatic half();
        repeat (20) @(posedge core_clk);
    endtask
    task automatic go(input logic m);
        sck <= m;
        half();
        cs_n <= 1'h0;
        half();
    endtask
    task automatic xb(input logic [7:0] tx, input logic d, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'h0;
            mosi <= tx[i];
            drv <= d;
            half();
            sck <= 1'h1;
            rx[i] = miso;
            half();
        end
    endtask
    task automatic fin(input logic m);
        sck <= m;
        drv <= 1'h0;
        half();
        cs_n <= 1'h1;
        repeat (260) @(posedge core_clk);
    endtask
endmodule

// *** tb/ssp_spi_port_tb.sv ***
// bench: host model makes frames, a small register file answers strobes
// assumes design, checker and host model compiled first
`timescale 1ns/1ps
`include "ssp_map.svh"

module ssp_spi_port_tb
    import ssp_pkg::*;
;
    logic        core_clk;
    logic        srst;
    logic        three_wire_select;
    ssp_byte_t   reg_rdata;
    ssp_addr_t   addr;
    ssp_byte_t   wdata;
    logic [2:0]  qn = 3'h0;
    logic [14:0] wq[$];
    logic        cs_n, sck, mosi, drv, io_o, io_oe_n, out_o, out_oe_n, wr, rd, mode;
    // a released line shows the inverse of its last level
    wire logic   io_ln = !io_oe_n ? io_o : drv ? mosi : ~io_o;
    wire logic   miso = three_wire_select ? io_ln : out_oe_n ? ~out_o : out_o;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;

    ssp_spi_port ssp_spi_port_i (.core_clk(core_clk), .srst(srst), .chip_select_n(cs_n), .serial_clock(sck),
        .serial_data_io_i(io_ln), .serial_data_io_o(io_o), .serial_data_io_oe_n(io_oe_n),
        .serial_data_out_o(out_o), .serial_data_out_oe_n(out_oe_n), .three_wire_select(three_wire_select),
        .reg_addr_q(addr), .reg_wdata_q(wdata), .reg_wr_q(wr), .reg_rd_q(rd), .reg_rdata(reg_rdata),
        .clock_mode_q(mode));
    ssp_host ssp_host_i (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .drv(drv), .miso(miso));

    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (rd) reg_rdata <= (addr == `SSP_QUEUE_ADDR) ? {5'h00, qn} : {1'h1, addr};
        if (rd && addr == `SSP_QUEUE_ADDR) qn <= qn + 3'h1;
        else if (cs_n) qn <= 3'h0;
        if (wr) wq.push_back({addr, wdata});
        if (cyc == 16000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd3(input logic [6:0] a, input logic [23:0] e);
        logic [7:0] rx;
        ssp_host_i.xb({1'h1, a}, 1'h1, rx);
        for (int i = 2; i >= 0; i--) begin
            ssp_host_i.xb(8'h00, 1'h0, rx);
            chk({8'h00, rx}, {8'h00, e[8*i +: 8]});
        end
    endtask
    task automatic t_write();
        logic [7:0] rx;
        ssp_host_i.go(1'h0);
        ssp_host_i.xb(8'h12, 1'h1, rx);
        ssp_host_i.xb(8'hA7, 1'h1, rx);
        ssp_host_i.xb(8'h05, 1'h1, rx);
        ssp_host_i.xb(8'h3C, 1'h1, rx);
        ssp_host_i.fin(1'h0);
        chk({1'h0, wq[0]}, 16'h12A7);
        chk({1'h0, wq[1]}, 16'h053C);
        wq.delete();
    endtask
    task automatic t_read();
        ssp_host_i.go(1'h1);
        rd3(7'h3F, 24'hBF_0001);
        ssp_host_i.fin(1'h1);
    endtask
    task automatic t_hybrid();
        logic [7:0] rx;
        three_wire_select <= 1'h1;
        ssp_host_i.go(1'h0);
        ssp_host_i.xb(8'h11, 1'h1, rx);
        ssp_host_i.xb(8'h5A, 1'h1, rx);
        rd3(7'h40, 24'h00_0102);
        ssp_host_i.fin(1'h0);
        chk({1'h0, wq[0]}, 16'h115A);
        wq.delete();
    endtask
    task automatic t_abort();
        logic [7:0] rx;
        ssp_host_i.go(1'h1);
        ssp_host_i.xb(8'h22, 1'h1, rx);
        ssp_host_i.fin(1'h1);
        chk(16'(wq.size()), 16'h0000);
        ssp_host_i.go(1'h1);
        ssp_host_i.xb(8'h33, 1'h1, rx);
        ssp_host_i.xb(8'h66, 1'h1, rx);
        ssp_host_i.fin(1'h1);
        chk({1'h0, wq[0]}, 16'h3366);
        wq.delete();
    endtask

    initial begin
        srst = 1'h1;
        three_wire_select = 1'h0;
        repeat (3) @(posedge core_clk);
        srst <= 1'h0;
        repeat (2) @(posedge core_clk);
        t_write();
        t_read();
        t_hybrid();
        t_abort();
        summarize();
    end
endmodule
